// File: pkg/dmt_pkg.sv
package dmt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB port.
  localparam logic [7:0] OFF_TAG_HI  = 8'h00;
  localparam logic [7:0] OFF_TAG_LO  = 8'h04;
  localparam logic [7:0] OFF_PHYS_HI = 8'h08;
  localparam logic [7:0] OFF_PHYS_LO = 8'h0c;
  localparam logic [7:0] OFF_LOCK    = 8'h10;
  localparam logic [7:0] OFF_LOAD    = 8'h14;
  localparam logic [7:0] OFF_CTRL    = 8'h18;
  localparam logic [7:0] OFF_FAULT   = 8'h1c;
  localparam logic [7:0] OFF_FADDR   = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values.
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_WALK_BIT    = 1;
  localparam int FLT_PAGE_BIT     = 0;
  localparam int FLT_PERM_BIT     = 1;
  localparam int TAGLO_SIZE_LSB   = 0;
  localparam int TAGLO_PRES_BIT   = 3;
  localparam int TAGLO_VLO_LSB    = 4;
  localparam int TAGLO_VHI_LSB    = 14;
  localparam int PHYSLO_PERM_LSB  = 8;
  localparam int PHYSLO_PA_LSB    = 10;
  localparam int LOCK_VICTIM_LSB  = 4;
  localparam int LOCK_BASE_LSB    = 10;
  localparam int IDX_W            = 5;
  localparam int ENTRIES          = 32;
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam logic [15:0] LOAD_CMD_VAL = 16'h0001;
  localparam logic [7:0]  PASS_UPPER   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Page size and permission encodings.
  localparam logic [1:0] SZ_1M     = 2'h0;
  localparam logic [1:0] SZ_64K    = 2'h1;
  localparam logic [1:0] SZ_4K     = 2'h2;
  localparam logic [1:0] SZ_1K     = 2'h3;
  localparam logic [1:0] PERM_NONE = 2'h0;
  localparam logic [1:0] PERM_RO   = 2'h2;
  localparam logic [1:0] PERM_RW   = 2'h3;

  typedef struct packed {
    logic        valid;
    logic        preserved;
    logic [1:0]  size;
    logic [21:0] tag;
    logic [21:0] ppn;
    logic [1:0]  perm;
  } dmt_entry_t;

  // Marks which of virtual bits 31..10 belong to the page number.
  function automatic logic [21:0] dmt_page_mask(input logic [1:0] size);
    case (size)
      SZ_1M:   dmt_page_mask = 22'h3ffc00;
      SZ_64K:  dmt_page_mask = 22'h3fffc0;
      SZ_4K:   dmt_page_mask = 22'h3ffffc;
      default: dmt_page_mask = 22'h3fffff;
    endcase
  endfunction

endpackage

// File: pkg/dmt_tlb_if.sv
`timescale 1ns/1ps
interface dmt_tlb_if;
  logic        load;
  logic [4:0]  idx;
  logic [15:0] tag_hi;
  logic [15:0] tag_lo;
  logic [15:0] phys_hi;
  logic [15:0] phys_lo;
  logic [31:0] vaddr;
  logic        hit;
  logic [31:0] paddr;
  logic [1:0]  perm;

  modport ctrl (output load, idx, tag_hi, tag_lo, phys_hi, phys_lo, vaddr,
                input hit, paddr, perm);
  modport store (input load, idx, tag_hi, tag_lo, phys_hi, phys_lo, vaddr,
                 output hit, paddr, perm);
endinterface

// File: hw/dmt_tlb_store.sv
`timescale 1ns/1ps
module dmt_tlb_store
  import dmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dmt_tlb_if.store tlb
);
  import dmt_pkg::*;

  typedef struct packed {
    dmt_entry_t [ENTRIES-1:0] ent;
  } dmt_store_t;

  dmt_store_t  st_r;
  dmt_store_t  st_nxt;
  dmt_entry_t  new_ent;
  logic [ENTRIES-1:0] hit_v;
  logic [31:0] pa_v [ENTRIES];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    new_ent.valid     = 1'b1;
    new_ent.preserved = tlb.tag_lo[TAGLO_PRES_BIT];
    new_ent.size      = tlb.tag_lo[TAGLO_SIZE_LSB +: 2];
    new_ent.tag       = {tlb.tag_hi[9:0], tlb.tag_lo[TAGLO_VHI_LSB +: 2],
                         tlb.tag_lo[TAGLO_VLO_LSB +: 10]};
    new_ent.ppn       = {tlb.phys_hi, tlb.phys_lo[PHYSLO_PA_LSB +: 6]};
    new_ent.perm      = tlb.phys_lo[PHYSLO_PERM_LSB +: 2];
    st_nxt = st_r;
    if (tlb.load) begin
      st_nxt.ent[tlb.idx] = new_ent;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every entry compares its own page number against the request.
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    logic [21:0] m;
    assign m = dmt_page_mask(st_r.ent[i].size);
    assign hit_v[i] = st_r.ent[i].valid &&
        (((st_r.ent[i].tag ^ tlb.vaddr[31:10]) & m) == 22'h000000);
    assign pa_v[i] = {(st_r.ent[i].ppn & m) | (tlb.vaddr[31:10] & ~m),
                      tlb.vaddr[9:0]};
  end

  // Overlapping pages are legal; the lowest index simply wins.
  always_comb begin
    tlb.hit   = 1'b0;
    tlb.paddr = 32'h00000000;
    tlb.perm  = PERM_NONE;
    for (int k = ENTRIES - 1; k >= 0; k--) begin
      if (hit_v[k]) begin
        tlb.hit   = 1'b1;
        tlb.paddr = pa_v[k];
        tlb.perm  = st_r.ent[k].perm;
      end
    end
  end

endmodule // dmt_tlb_store

// File: hw/dmt_mmu.sv
// What this block does
// - After reset disabled, pass through to low 16M
// - Enabled: map 24-bit address to 32-bit
// - Page sizes 1M, 64K, 4K or 1K
// - New entry stored at victim index
// - Writing 1 to load command commits entry
// - Load only while table walk is off
// - Tag word layout of virtual bits
// - Physical word layout and permission at bit 8
// - Lock counter: victim at 4, base at 10
// - Base 0..31, victim between base and 31
// - Permission: none, read only, read write
// - Each entry carries a preserved flag
// - No check for overlapping physical mappings
// - Thirty-two entries of tag and data
// - Match valid tags, use paired physical bits
// - Miss or forbidden access faults and interrupts
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module dmt_mmu
  import dmt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dsp_req,
  input  wire logic        dsp_wr,
  input  wire logic [23:0] dsp_addr,
  output logic             tc_req,
  output logic             tc_wr,
  output logic      [31:0] tc_addr,
  output logic             mmu_irq
);
  import dmt_pkg::*;

  typedef struct packed {
    logic [15:0] tag_hi;
    logic [15:0] tag_lo;
    logic [15:0] phys_hi;
    logic [15:0] phys_lo;
    logic [15:0] lock;
    logic        enable;
    logic        walk;
    logic        flt_page;
    logic        flt_perm;
    logic [23:0] flt_addr;
    logic        ld;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tc_req;
    logic        tc_wr;
    logic [31:0] tc_addr;
    logic        irq;
  } dmt_state_t;

  dmt_state_t  st_r;
  dmt_state_t  st_nxt;
  dmt_tlb_if   tlb ();

  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic [31:0] rdata;
  logic [4:0]  victim;
  logic [4:0]  base;
  logic        load_ok;
  logic        set_page;
  logic        set_perm;
  logic        clr_page;
  logic        clr_perm;

  ////////////////////////////////////////////////////////////////////////////
  // Translation store and matching.
  dmt_tlb_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .tlb     (tlb.store)
  );

  assign tlb.load    = st_r.ld;
  assign tlb.idx     = victim;
  assign tlb.tag_hi  = st_r.tag_hi;
  assign tlb.tag_lo  = st_r.tag_lo;
  assign tlb.phys_hi = st_r.phys_hi;
  assign tlb.phys_lo = st_r.phys_lo;
  assign tlb.vaddr   = {PASS_UPPER, dsp_addr};

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  always_comb begin
    victim = st_r.lock[LOCK_VICTIM_LSB +: IDX_W];
    base   = st_r.lock[LOCK_BASE_LSB +: IDX_W];
    setup  = psel && !penable;
    wr_acc = psel && penable && st_r.pready && pwrite;
    mapped = 1'b1;
    rdata  = 32'h00000000;
    case (paddr)
      OFF_TAG_HI:  rdata = {16'h0000, st_r.tag_hi};
      OFF_TAG_LO:  rdata = {16'h0000, st_r.tag_lo};
      OFF_PHYS_HI: rdata = {16'h0000, st_r.phys_hi};
      OFF_PHYS_LO: rdata = {16'h0000, st_r.phys_lo};
      OFF_LOCK:    rdata = {16'h0000, st_r.lock};
      OFF_LOAD:    rdata = 32'h00000000;
      OFF_CTRL:    rdata = {30'h00000000, st_r.walk, st_r.enable};
      OFF_FAULT:   rdata = {30'h00000000, st_r.flt_perm, st_r.flt_page};
      OFF_FADDR:   rdata = {8'h00, st_r.flt_addr};
      default:     mapped = 1'b0;
    endcase
    // A victim below the locked base would overwrite a locked entry.
    load_ok = !st_r.walk && (victim >= base);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    st_nxt        = st_r;
    st_nxt.ld     = 1'b0;
    st_nxt.pready = setup;
    set_page      = 1'b0;
    set_perm      = 1'b0;
    clr_page      = 1'b0;
    clr_perm      = 1'b0;
    if (setup) begin
      st_nxt.prdata  = rdata;
      st_nxt.pslverr = !mapped;
    end
    if (wr_acc) begin
      case (paddr)
        OFF_TAG_HI:  st_nxt.tag_hi  = pwdata[15:0];
        OFF_TAG_LO:  st_nxt.tag_lo  = pwdata[15:0];
        OFF_PHYS_HI: st_nxt.phys_hi = pwdata[15:0];
        OFF_PHYS_LO: st_nxt.phys_lo = pwdata[15:0];
        OFF_LOCK:    st_nxt.lock    = pwdata[15:0];
        OFF_LOAD: begin
          if (pwdata[15:0] == LOAD_CMD_VAL && load_ok) begin
            st_nxt.ld = 1'b1;
          end
        end
        OFF_CTRL: begin
          // Entries are left untouched; the next request sees the change.
          st_nxt.enable = pwdata[CTRL_EN_BIT];
          st_nxt.walk   = pwdata[CTRL_WALK_BIT];
        end
        OFF_FAULT: begin
          clr_page = pwdata[FLT_PAGE_BIT];
          clr_perm = pwdata[FLT_PERM_BIT];
        end
        default: ;
      endcase
    end
    st_nxt.tc_req = 1'b0;
    if (dsp_req) begin
      if (!st_r.enable) begin
        st_nxt.tc_req  = 1'b1;
        st_nxt.tc_wr   = dsp_wr;
        st_nxt.tc_addr = {PASS_UPPER, dsp_addr};
      end else if (!tlb.hit) begin
        set_page = 1'b1;
      end else if (tlb.perm == PERM_RW ||
                   (tlb.perm == PERM_RO && !dsp_wr)) begin
        st_nxt.tc_req  = 1'b1;
        st_nxt.tc_wr   = dsp_wr;
        st_nxt.tc_addr = tlb.paddr;
      end else begin
        set_perm = 1'b1;
      end
      if (set_page || set_perm) begin
        st_nxt.flt_addr = dsp_addr;
      end
    end
    // A fault in the same cycle as its clear is kept.
    st_nxt.flt_page = (st_r.flt_page && !clr_page) || set_page;
    st_nxt.flt_perm = (st_r.flt_perm && !clr_perm) || set_perm;
    st_nxt.irq      = st_nxt.flt_page || st_nxt.flt_perm;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= '0;
      st_r.tag_hi  <= REG_RST;
      st_r.tag_lo  <= REG_RST;
      st_r.phys_hi <= REG_RST;
      st_r.phys_lo <= REG_RST;
      st_r.lock    <= REG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign tc_req  = st_r.tc_req;
  assign tc_wr   = st_r.tc_wr;
  assign tc_addr = st_r.tc_addr;
  assign mmu_irq = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load_write;
    psel && penable && pready && pwrite && paddr == OFF_LOAD &&
    pwdata[15:0] == LOAD_CMD_VAL;
  endsequence

  sequence s_load_taken;
    tlb.load ##1 !tlb.load;
  endsequence

  AST_PASS_THROUGH: assert property (
    dsp_req && !st_r.enable |=> tc_req && tc_addr[31:24] == 8'h00 &&
      tc_addr[23:0] == $past(dsp_addr))
    else $error("Disabled request was not passed through.");

  AST_TRANSLATE: assert property (
    dsp_req && st_r.enable && tlb.hit && tlb.perm == PERM_RW
      |=> tc_req && tc_addr == $past(tlb.paddr) && tc_wr == $past(dsp_wr))
    else $error("Translated address did not reach the controller.");

  AST_MISS_FAULT: assert property (
    dsp_req && st_r.enable && !tlb.hit
      |=> !tc_req && st_r.flt_page && mmu_irq)
    else $error("Miss was not blocked and reported.");

  AST_RO_WRITE: assert property (
    dsp_req && dsp_wr && st_r.enable && tlb.hit && tlb.perm == PERM_RO
      |=> !tc_req && st_r.flt_perm && mmu_irq)
    else $error("Write to read only page was not refused.");

  AST_NO_ACCESS: assert property (
    dsp_req && st_r.enable && tlb.hit && tlb.perm == PERM_NONE
      |=> !tc_req && st_r.flt_perm)
    else $error("Access to no-access page was not refused.");

  AST_LOAD_CMD: assert property (
    s_load_write and (!st_r.walk && victim >= base) |=> s_load_taken)
    else $error("Load command did not commit an entry.");

  AST_LOAD_GUARD: assert property (
    tlb.load |-> !$past(st_r.walk) && victim >= base)
    else $error("Entry loaded with walk on or victim below base.");

  AST_APB_READY: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("APB ready was not a single access cycle.");

  AST_FAULT_HOLD: assert property (
    st_r.flt_page && !(wr_acc && paddr == OFF_FAULT &&
      pwdata[FLT_PAGE_BIT]) |=> st_r.flt_page && mmu_irq)
    else $error("Page fault flag was lost without a clear.");

  AST_PERM_HOLD: assert property (
    st_r.flt_perm && !(wr_acc && paddr == OFF_FAULT &&
      pwdata[FLT_PERM_BIT]) |=> st_r.flt_perm && mmu_irq)
    else $error("Permission fault flag was lost without a clear.");

  AST_FAULT_CLEAR: assert property (
    wr_acc && paddr == OFF_FAULT && pwdata[FLT_PAGE_BIT] && !dsp_req
      |=> !st_r.flt_page)
    else $error("Page fault flag survived its clear.");

  AST_FAULT_ADDR: assert property (
    dsp_req && st_r.enable && !tlb.hit
      |=> st_r.flt_addr == $past(dsp_addr))
    else $error("Faulting address was not recorded.");

  AST_NO_SPURIOUS: assert property (
    !dsp_req |=> !tc_req)
    else $error("Controller request without a core request.");

  AST_RO_READ: assert property (
    dsp_req && !dsp_wr && st_r.enable && tlb.hit && tlb.perm == PERM_RO
      |=> tc_req && !tc_wr && tc_addr == $past(tlb.paddr))
    else $error("Read of read only page was not passed on.");

  AST_DISABLED_QUIET: assert property (
    dsp_req && !st_r.enable && !mmu_irq |=> !mmu_irq)
    else $error("Disabled unit raised a fault.");

  AST_WALK_REFUSE: assert property (
    wr_acc && paddr == OFF_LOAD && st_r.walk |=> !tlb.load)
    else $error("Entry loaded while table walk was on.");

  AST_BASE_REFUSE: assert property (
    wr_acc && paddr == OFF_LOAD && victim < base |=> !tlb.load)
    else $error("Entry loaded below the locked base.");

  AST_CMD_VALUE: assert property (
    wr_acc && paddr == OFF_LOAD && pwdata[15:0] != LOAD_CMD_VAL
      |=> !tlb.load)
    else $error("Load command other than one committed an entry.");

endmodule // dmt_mmu

// File: tb/dmt_dsp_model.sv
`timescale 1ns/1ps
module dmt_dsp_model (
  input  wire logic        pclk,
  output logic             dsp_req,
  output logic             dsp_wr,
  output logic      [23:0] dsp_addr,
  input  wire logic        tc_req,
  input  wire logic        tc_wr,
  input  wire logic [31:0] tc_addr,
  input  wire logic        mmu_irq
);
  initial begin
    dsp_req  = 1'b0;
    dsp_wr   = 1'b0;
    dsp_addr = 24'h000000;
  end

  // One core access, then the controller side in the answer cycle.
  task automatic access(input logic wr, input logic [23:0] a,
                        output logic q, output logic qw,
                        output logic [31:0] sa, output logic irq);
    @(posedge pclk);
    dsp_req  <= 1'b1;
    dsp_wr   <= wr;
    dsp_addr <= a;
    @(posedge pclk);
    dsp_req  <= 1'b0;
    // A released bus shows the inverse so stale values cannot pass.
    dsp_wr   <= ~wr;
    dsp_addr <= ~a;
    @(posedge pclk);
    q   = tc_req;
    qw  = tc_wr;
    sa  = tc_addr;
    irq = mmu_irq;
  endtask
endmodule // dmt_dsp_model

// File: tb/dmt_mmu_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module dmt_mmu_bench;
  import dmt_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dsp_req;
  logic        dsp_wr;
  logic [23:0] dsp_addr;
  logic        tc_req;
  logic        tc_wr;
  logic [31:0] tc_addr;
  logic        mmu_irq;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          comparisons;

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  dmt_mmu dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dsp_req(dsp_req), .dsp_wr(dsp_wr), .dsp_addr(dsp_addr),
    .tc_req(tc_req), .tc_wr(tc_wr), .tc_addr(tc_addr), .mmu_irq(mmu_irq));

  dmt_dsp_model dsp (.pclk(pclk), .dsp_req(dsp_req), .dsp_wr(dsp_wr),
    .dsp_addr(dsp_addr), .tc_req(tc_req), .tc_wr(tc_wr),
    .tc_addr(tc_addr), .mmu_irq(mmu_irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic load(input logic [31:0] va, input logic [31:0] pa,
                      input logic [1:0] sz, input logic [1:0] pm,
                      input int vic, input int bas, input logic [31:0] cmd);
    apb(1'b1, OFF_TAG_HI, {22'h0, va[31:22]});
    apb(1'b1, OFF_TAG_LO, {16'h0, va[21:20], va[19:10], 2'b10, sz});
    apb(1'b1, OFF_PHYS_HI, {16'h0, pa[31:16]});
    apb(1'b1, OFF_PHYS_LO, {16'h0, pa[15:10], pm, 8'h00});
    apb(1'b1, OFF_LOCK, {17'h0, bas[4:0], 1'b0, vic[4:0], 4'h0});
    apb(1'b1, OFF_LOAD, cmd);
  endtask

  function automatic logic [31:0] xl(input logic [31:0] pa,
                                     input logic [23:0] a,
                                     input logic [1:0] sz);
    logic [31:0] m;
    m = (sz == SZ_1M) ? 32'h000fffff : (sz == SZ_64K) ? 32'h0000ffff :
        (sz == SZ_4K) ? 32'h00000fff : 32'h000003ff;
    return (pa & ~m) | ({8'h00, a} & m);
  endfunction

  task automatic dchk(input logic w, input logic [23:0] a,
                      input logic [1:0] flt, input logic [31:0] ea);
    logic        q;
    logic        qw;
    logic        irq;
    logic [31:0] sa;
    dsp.access(w, a, q, qw, sa, irq);
    `CHK(q, (flt == 2'b00))
    `CHK(irq, (flt != 2'b00))
    if (flt == 2'b00) begin
      `CHK(sa, ea)
      `CHK(qw, w)
    end else begin
      apb(1'b0, OFF_FAULT, 32'h0);
      `CHK(rd, {30'h0, flt})
      apb(1'b0, OFF_FADDR, 32'h0);
      `CHK(rd, {8'h00, a})
      apb(1'b1, OFF_FAULT, 32'h3);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    dchk(1'b1, 24'h8abcde, 2'b00, 32'h008abcde);
    dchk(1'b0, 24'hffffff, 2'b00, 32'h00ffffff);
  endtask

  task automatic t_regs();
    apb(1'b1, OFF_LOCK, 32'h00007df0);
    apb(1'b0, OFF_LOCK, 32'h0);
    `CHK(rd, 32'h00007df0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b0, OFF_LOAD, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, OFF_TAG_LO, 32'h0000c008);
    apb(1'b0, OFF_TAG_LO, 32'h0);
    `CHK(rd, 32'h0000c008)
  endtask

  task automatic t_pages();
    logic [31:0] va [4] = '{32'h800000, 32'ha00000, 32'hc00000, 32'he00000};
    logic [31:0] pa [4] = '{32'h10000000, 32'h0c400000, 32'h20000000,
                            32'h10300000};
    logic [23:0] of [4] = '{24'h0fffff, 24'h00ffff, 24'h000fff, 24'h0003ff};
    logic [1:0]  sz [4] = '{SZ_1M, SZ_64K, SZ_4K, SZ_1K};
    logic [23:0] a;
    for (int i = 0; i < 4; i++) begin
      load(va[i], pa[i], sz[i], PERM_RW, 28 + i, 0, 32'h1);
    end
    apb(1'b1, OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      a = va[i][23:0] | of[i];
      dchk(1'b1, a, 2'b00, xl(pa[i], a, sz[i]));
      dchk(1'b0, a + 24'h1, 2'b01, 32'h0);
    end
  endtask

  task automatic t_perm();
    load(32'h400000, 32'h30000000, SZ_4K, PERM_RO, 5, 0, 32'h1);
    load(32'h500000, 32'h30001000, SZ_4K, PERM_NONE, 6, 0, 32'h1);
    dchk(1'b0, 24'h400123, 2'b00, 32'h30000123);
    dchk(1'b1, 24'h400123, 2'b10, 32'h0);
    dchk(1'b0, 24'h500004, 2'b10, 32'h0);
    load(32'h300000, 32'h30002000, SZ_4K, 2'h1, 9, 0, 32'h1);
    dchk(1'b0, 24'h300000, 2'b10, 32'h0);
  endtask

  task automatic t_guard();
    apb(1'b1, OFF_CTRL, 32'h3);
    load(32'h600000, 32'h40000000, SZ_1M, PERM_RW, 7, 0, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    dchk(1'b0, 24'h600010, 2'b01, 32'h0);
    load(32'h600000, 32'h40000000, SZ_1M, PERM_RW, 2, 10, 32'h1);
    dchk(1'b0, 24'h600010, 2'b01, 32'h0);
    load(32'h600000, 32'h40000000, SZ_1M, PERM_RW, 8, 0, 32'h2);
    dchk(1'b0, 24'h600010, 2'b01, 32'h0);
    load(32'h600000, 32'h40000000, SZ_1M, PERM_RW, 31, 31, 32'h1);
    dchk(1'b0, 24'h600010, 2'b00, 32'h40000010);
    load(32'h700000, 32'h10000000, SZ_1M, PERM_RW, 31, 0, 32'h1);
    dchk(1'b0, 24'h600010, 2'b01, 32'h0);
    dchk(1'b1, 24'h700020, 2'b00, 32'h10000020);
    dchk(1'b1, 24'h800020, 2'b00, 32'h10000020);
  endtask

  task automatic t_disable();
    apb(1'b1, OFF_CTRL, 32'h0);
    dchk(1'b0, 24'h8abcde, 2'b00, 32'h008abcde);
    apb(1'b1, OFF_CTRL, 32'h1);
    dchk(1'b0, 24'h8abcde, 2'b00, 32'h100abcde);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    errors      = 0;
    comparisons = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_pages();
    t_perm();
    t_guard();
    t_disable();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule // dmt_mmu_bench
